/* File: rtl/vtc_trim_bank.sv */
// Read-only bank of temperature trim coefficients for the first cell
// voltage channel, reached over APB, with a load port for trim values.
// Assumes trim loads come from logic on pclk; APB master keeps to the bus protocol.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "vtc_consts.svh"

module vtc_trim_bank (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`VTC_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic trim_load_valid,
   input wire logic [7:0] trim_load_addr,
   input wire logic [7:0] trim_load_data,
   output logic [13:0] gain_order2_coeff,
   output logic [11:0] gain_order3_coeff,
   output logic [11:0] gain_order4_coeff,
   output logic [13:0] offset_order0_coeff,
   output logic [4:0] gain_order1_coeff_hi,
   output logic gain_order1_coeff_lsb
);

   vtc_pkg::vtc_bank_s st_r;
   vtc_pkg::vtc_bank_s st_nxt;
   vtc_pkg::vtc_dec_s bus_dec;
   vtc_pkg::vtc_dec_s ld_dec;
   logic bus_aligned;
   logic setup_ph;
   logic access_ph;
   logic [`VTC_SLOTS-1:0][7:0] img;

   vtc_trim_if tif ();

   // Register index to stored byte; anything else misses
   function automatic vtc_pkg::vtc_dec_s vtc_decode(input logic [7:0] off);
      vtc_pkg::vtc_dec_s d;
      d.hit = 1'b1;
      d.slot = vtc_pkg::VTC_SLOT_O1B0;
      unique case (off)
         `VTC_OFF_O1B0: d.slot = vtc_pkg::VTC_SLOT_O1B0;
         `VTC_OFF_O1HI_O2LO: d.slot = vtc_pkg::VTC_SLOT_O1HI_O2LO;
         `VTC_OFF_O2MID: d.slot = vtc_pkg::VTC_SLOT_O2MID;
         `VTC_OFF_O2HI_O3LO: d.slot = vtc_pkg::VTC_SLOT_O2HI_O3LO;
         `VTC_OFF_O3HI: d.slot = vtc_pkg::VTC_SLOT_O3HI;
         `VTC_OFF_O4LO: d.slot = vtc_pkg::VTC_SLOT_O4LO;
         `VTC_OFF_O4HI_OFFLO: d.slot = vtc_pkg::VTC_SLOT_O4HI_OFFLO;
         `VTC_OFF_OFFMID: d.slot = vtc_pkg::VTC_SLOT_OFFMID;
         `VTC_OFF_OFFHI: d.slot = vtc_pkg::VTC_SLOT_OFFHI;
         default: d.hit = 1'b0;
      endcase
      return d;
   endfunction

   // Bus address decode: word aligned, upper bits zero
   assign bus_aligned = (paddr[1:0] == 2'b00) && (paddr[`VTC_ADDR_W-1:10] == '0);
   assign bus_dec = vtc_decode(paddr[9:2]);
   assign ld_dec = vtc_decode(trim_load_addr);
   assign setup_ph = psel && !penable;
   assign access_ph = psel && penable;

   // Read data is fetched in the setup phase so the access needs no wait state
   assign tif.rd_en = setup_ph && !pwrite;
   assign tif.rd_hit = bus_dec.hit && bus_aligned;
   assign tif.rd_slot = bus_dec.slot;

   // Only the trim load port writes the store; the bus never does
   assign tif.ld_en = trim_load_valid && ld_dec.hit;
   assign tif.ld_slot = ld_dec.slot;
   assign tif.ld_data = trim_load_data;

   vtc_trim_store u_store (
      .pclk(pclk),
      .presetn(presetn),
      .bus(tif.store)
   );

   // Error flag captured at setup; a write to a bank register is silently
   // ignored, an access to any other address reports an error
   always_comb begin
      st_nxt = st_r;
      if (setup_ph) begin
         st_nxt.err = !(bus_dec.hit && bus_aligned);
      end
      if (tif.ld_en) begin
         st_nxt.loaded = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '{err: 1'b0, loaded: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // Zero wait states: data was registered during setup
   assign pready = 1'b1;
   assign prdata = {24'h000000, tif.rd_data};
   assign pslverr = access_ph && st_r.err;

   // Coefficients assembled from their fragments, high fragment first
   assign img = tif.img;
   assign gain_order2_coeff = {img[vtc_pkg::VTC_SLOT_O2HI_O3LO][2:0],
                               img[vtc_pkg::VTC_SLOT_O2MID],
                               img[vtc_pkg::VTC_SLOT_O1HI_O2LO][7:`VTC_O2LO_POS]};
   assign gain_order3_coeff = {img[vtc_pkg::VTC_SLOT_O3HI][6:0],
                               img[vtc_pkg::VTC_SLOT_O2HI_O3LO][7:`VTC_O3LO_POS]};
   assign gain_order4_coeff = {img[vtc_pkg::VTC_SLOT_O4HI_OFFLO][3:0],
                               img[vtc_pkg::VTC_SLOT_O4LO]};
   assign offset_order0_coeff = {img[vtc_pkg::VTC_SLOT_OFFHI][1:0],
                                 img[vtc_pkg::VTC_SLOT_OFFMID],
                                 img[vtc_pkg::VTC_SLOT_O4HI_OFFLO][7:`VTC_OFFLO_POS]};
   assign gain_order1_coeff_hi = img[vtc_pkg::VTC_SLOT_O1HI_O2LO][4:0];
   assign gain_order1_coeff_lsb = img[vtc_pkg::VTC_SLOT_O1B0][`VTC_O1B0_POS];

   // Checks on the read view and the bank contents
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Setup of a read to one register, then its access, with no load between
   sequence s_rd_setup(logic [7:0] off);
      psel && !penable && !pwrite && !trim_load_valid
         && paddr == {{(`VTC_ADDR_W-10){1'b0}}, off, 2'b00};
   endsequence

   sequence s_rd_access;
      psel && penable && !pwrite;
   endsequence

   AST_O2LO: assert property (
      s_rd_setup(`VTC_OFF_O1HI_O2LO) ##1 s_rd_access
         |-> prdata[7:5] == gain_order2_coeff[2:0])
      else $error("0x54 high bits differ from gain order-2 low bits");

   AST_O1HI: assert property (
      s_rd_setup(`VTC_OFF_O1HI_O2LO) ##1 s_rd_access
         |-> prdata[4:0] == gain_order1_coeff_hi && prdata[31:8] == 24'h000000)
      else $error("0x54 low bits differ from gain order-1 high bits");

   AST_O2MID: assert property (
      s_rd_setup(`VTC_OFF_O2MID) ##1 s_rd_access
         |-> prdata[7:0] == gain_order2_coeff[10:3])
      else $error("0x55 differs from gain order-2 middle bits");

   AST_O3LO: assert property (
      s_rd_setup(`VTC_OFF_O2HI_O3LO) ##1 s_rd_access
         |-> prdata[7:3] == gain_order3_coeff[4:0])
      else $error("0x56 high bits differ from gain order-3 low bits");

   AST_O2HI: assert property (
      s_rd_setup(`VTC_OFF_O2HI_O3LO) ##1 s_rd_access
         |-> prdata[2:0] == gain_order2_coeff[13:11])
      else $error("0x56 low bits differ from gain order-2 high bits");

   AST_O3HI: assert property (
      s_rd_setup(`VTC_OFF_O3HI) ##1 s_rd_access
         |-> prdata[6:0] == gain_order3_coeff[11:5] && !prdata[7])
      else $error("0x57 differs from gain order-3 high bits or spare set");

   AST_O4LO: assert property (
      s_rd_setup(`VTC_OFF_O4LO) ##1 s_rd_access
         |-> prdata[7:0] == gain_order4_coeff[7:0])
      else $error("0x58 differs from gain order-4 low bits");

   AST_OFFLO: assert property (
      s_rd_setup(`VTC_OFF_O4HI_OFFLO) ##1 s_rd_access
         |-> prdata[7:4] == offset_order0_coeff[3:0])
      else $error("0x59 high bits differ from offset low bits");

   AST_O4HI: assert property (
      s_rd_setup(`VTC_OFF_O4HI_OFFLO) ##1 s_rd_access
         |-> prdata[3:0] == gain_order4_coeff[11:8])
      else $error("0x59 low bits differ from gain order-4 high bits");

   AST_OFFMID: assert property (
      s_rd_setup(`VTC_OFF_OFFMID) ##1 s_rd_access
         |-> prdata[7:0] == offset_order0_coeff[11:4])
      else $error("0x5A differs from offset middle bits");

   AST_OFFHI: assert property (
      s_rd_setup(`VTC_OFF_OFFHI) ##1 s_rd_access
         |-> prdata[1:0] == offset_order0_coeff[13:12] && prdata[7:2] == 6'h00)
      else $error("0x5B differs from offset high bits");

   AST_O1B0: assert property (
      s_rd_setup(`VTC_OFF_O1B0) ##1 s_rd_access
         |-> prdata[7] == gain_order1_coeff_lsb && prdata[6:0] == 7'h00)
      else $error("0x52 top bit differs from gain order-1 bit 0");

   AST_RO: assert property (
      psel && penable && pwrite && !trim_load_valid
         |=> $stable(gain_order2_coeff) && $stable(gain_order3_coeff)
            && $stable(gain_order4_coeff) && $stable(offset_order0_coeff)
            && $stable(gain_order1_coeff_hi) && $stable(gain_order1_coeff_lsb))
      else $error("Bus write changed the trim contents");

   AST_WR_OK: assert property (
      setup_ph && pwrite && bus_aligned && bus_dec.hit ##1 access_ph |-> !pslverr)
      else $error("Write to a bank register reported an error");

   AST_ZERO: assert property (
      !st_r.loaded |-> gain_order2_coeff == 14'h0000 && gain_order3_coeff == 12'h000
         && gain_order4_coeff == 12'h000 && offset_order0_coeff == 14'h0000
         && gain_order1_coeff_hi == 5'h00 && !gain_order1_coeff_lsb)
      else $error("Trim contents not zero before the first load");

   AST_LOAD: assert property (
      trim_load_valid && trim_load_addr == `VTC_OFF_O4LO
         |=> gain_order4_coeff[7:0] == $past(trim_load_data))
      else $error("Loaded byte did not reach gain order-4 low bits");

   AST_UNMAPPED: assert property (
      setup_ph && !(bus_aligned && bus_dec.hit) && !pwrite ##1 access_ph
         |-> pslverr && prdata == 32'h00000000)
      else $error("Unmapped read did not answer with error and zero data");

   AST_WR_ERR: assert property (
      setup_ph && pwrite && !(bus_aligned && bus_dec.hit) ##1 access_ph |-> pslverr)
      else $error("Write to an unmapped address reported no error");

   // Bus handshake: never a wait state, error only in the access phase
   AST_PREADY: assert property (
      psel && penable |-> pready)
      else $error("Access phase saw pready low");

   AST_ERR_IDLE: assert property (
      !(psel && penable) |-> !pslverr)
      else $error("Error flag shown outside an access phase");

   // Read data is only refreshed by a read setup, so a load cannot tear it
   AST_RD_HOLD: assert property (
      !(setup_ph && !pwrite) |=> $stable(prdata))
      else $error("Read data moved without a read setup");

   // One load of a mapped byte, seen on the coefficient outputs an edge later
   sequence s_load(logic [7:0] off);
      trim_load_valid && trim_load_addr == off;
   endsequence

   AST_LD_O1B0: assert property (
      s_load(`VTC_OFF_O1B0) |=> gain_order1_coeff_lsb == $past(trim_load_data[7]))
      else $error("Loaded byte did not reach gain order-1 bit 0");

   AST_LD_O1HI_O2LO: assert property (
      s_load(`VTC_OFF_O1HI_O2LO) |=> gain_order1_coeff_hi == $past(trim_load_data[4:0])
         && gain_order2_coeff[2:0] == $past(trim_load_data[7:5]))
      else $error("Loaded byte did not reach gain order-1 high or order-2 low bits");

   AST_LD_O2MID: assert property (
      s_load(`VTC_OFF_O2MID) |=> gain_order2_coeff[10:3] == $past(trim_load_data))
      else $error("Loaded byte did not reach gain order-2 middle bits");

   AST_LD_O2HI_O3LO: assert property (
      s_load(`VTC_OFF_O2HI_O3LO) |=> gain_order2_coeff[13:11] == $past(trim_load_data[2:0])
         && gain_order3_coeff[4:0] == $past(trim_load_data[7:3]))
      else $error("Loaded byte did not reach gain order-2 high or order-3 low bits");

   AST_LD_O3HI: assert property (
      s_load(`VTC_OFF_O3HI) |=> gain_order3_coeff[11:5] == $past(trim_load_data[6:0]))
      else $error("Loaded byte did not reach gain order-3 high bits");

   AST_LD_O4HI_OFFLO: assert property (
      s_load(`VTC_OFF_O4HI_OFFLO) |=> gain_order4_coeff[11:8] == $past(trim_load_data[3:0])
         && offset_order0_coeff[3:0] == $past(trim_load_data[7:4]))
      else $error("Loaded byte did not reach gain order-4 high or offset low bits");

   AST_LD_OFFMID: assert property (
      s_load(`VTC_OFF_OFFMID) |=> offset_order0_coeff[11:4] == $past(trim_load_data))
      else $error("Loaded byte did not reach offset middle bits");

   AST_LD_OFFHI: assert property (
      s_load(`VTC_OFF_OFFHI) |=> offset_order0_coeff[13:12] == $past(trim_load_data[1:0]))
      else $error("Loaded byte did not reach offset high bits");

   // Loads to offsets outside the bank must leave every coefficient alone
   AST_LD_MISS: assert property (
      trim_load_valid && !ld_dec.hit
         |=> $stable(gain_order2_coeff) && $stable(gain_order3_coeff)
            && $stable(gain_order4_coeff) && $stable(offset_order0_coeff)
            && $stable(gain_order1_coeff_hi) && $stable(gain_order1_coeff_lsb))
      else $error("Load to an unmapped offset changed the trim contents");

endmodule

/* File: common/vtc_consts.svh */
// Constants for the cell-voltage trim coefficient bank: offsets, bit masks,
// field positions and reset values. Included by the package users.
`ifndef VTC_CONSTS_SVH
`define VTC_CONSTS_SVH

// Register offsets (register indices; byte address is four times these)
`define VTC_OFF_O1B0 8'h52
`define VTC_OFF_O1HI_O2LO 8'h54
`define VTC_OFF_O2MID 8'h55
`define VTC_OFF_O2HI_O3LO 8'h56
`define VTC_OFF_O3HI 8'h57
`define VTC_OFF_O4LO 8'h58
`define VTC_OFF_O4HI_OFFLO 8'h59
`define VTC_OFF_OFFMID 8'h5A
`define VTC_OFF_OFFHI 8'h5B

// Bus address width and number of stored bytes
`define VTC_ADDR_W 12
`define VTC_SLOTS 9

// Reset value of every stored byte
`define VTC_TRIM_RST 8'h00

// Bits that hold trim data in each stored byte
`define VTC_MASK_FULL 8'hFF
`define VTC_MASK_O1B0 8'h80
`define VTC_MASK_O3HI 8'h7F
`define VTC_MASK_OFFHI 8'h03

// Field positions inside the stored bytes
`define VTC_O1B0_POS 7
`define VTC_O2LO_POS 5
`define VTC_O3LO_POS 3
`define VTC_OFFLO_POS 4

`endif

/* File: common/vtc_pkg.sv */
// Types shared by the trim coefficient bank and its byte store.
// Assumes the constants header is included before this package is used.
`include "vtc_consts.svh"

package vtc_pkg;

   // One stored byte per coefficient fragment register
   typedef enum logic [3:0] {
      VTC_SLOT_O1B0,
      VTC_SLOT_O1HI_O2LO,
      VTC_SLOT_O2MID,
      VTC_SLOT_O2HI_O3LO,
      VTC_SLOT_O3HI,
      VTC_SLOT_O4LO,
      VTC_SLOT_O4HI_OFFLO,
      VTC_SLOT_OFFMID,
      VTC_SLOT_OFFHI
   } vtc_slot_e;

   typedef logic [7:0] vtc_byte_t;

   typedef struct packed {
      logic hit;
      vtc_slot_e slot;
   } vtc_dec_s;

   // Byte store state: trim image plus registered read data
   typedef struct packed {
      logic [`VTC_SLOTS-1:0][7:0] img;
      vtc_byte_t rd_data;
   } vtc_store_s;

   // Bus side state
   typedef struct packed {
      logic err;
      logic loaded;
   } vtc_bank_s;

endpackage

/* File: common/vtc_trim_if.sv */
// Link between the bus front end and the trim byte store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`include "vtc_consts.svh"

interface vtc_trim_if;
   logic rd_en;
   logic rd_hit;
   vtc_pkg::vtc_slot_e rd_slot;
   vtc_pkg::vtc_byte_t rd_data;
   logic ld_en;
   vtc_pkg::vtc_slot_e ld_slot;
   vtc_pkg::vtc_byte_t ld_data;
   logic [`VTC_SLOTS-1:0][7:0] img;

   modport ctrl (
      output rd_en, rd_hit, rd_slot, ld_en, ld_slot, ld_data,
      input rd_data, img
   );
   modport store (
      input rd_en, rd_hit, rd_slot, ld_en, ld_slot, ld_data,
      output rd_data, img
   );
endinterface

/* File: rtl/vtc_trim_store.sv */
// Byte store for the trim image with a registered read port.
// Assumes loads and reads come from logic on pclk.
`timescale 1ns/1ps
`include "vtc_consts.svh"

module vtc_trim_store (
   input wire logic pclk,
   input wire logic presetn,
   vtc_trim_if.store bus
);

   vtc_pkg::vtc_store_s st_r;
   vtc_pkg::vtc_store_s st_nxt;

   // Only bits that carry trim data are kept; spare bits stay zero
   function automatic vtc_pkg::vtc_byte_t vtc_mask(input vtc_pkg::vtc_slot_e s);
      vtc_pkg::vtc_byte_t m;
      m = `VTC_MASK_FULL;
      unique case (s)
         vtc_pkg::VTC_SLOT_O1B0: m = `VTC_MASK_O1B0;
         vtc_pkg::VTC_SLOT_O3HI: m = `VTC_MASK_O3HI;
         vtc_pkg::VTC_SLOT_OFFHI: m = `VTC_MASK_OFFHI;
         vtc_pkg::VTC_SLOT_O1HI_O2LO,
         vtc_pkg::VTC_SLOT_O2MID,
         vtc_pkg::VTC_SLOT_O2HI_O3LO,
         vtc_pkg::VTC_SLOT_O4LO,
         vtc_pkg::VTC_SLOT_O4HI_OFFLO,
         vtc_pkg::VTC_SLOT_OFFMID: m = `VTC_MASK_FULL;
         default: m = 8'h00;
      endcase
      return m;
   endfunction

   // Load path and read capture; unmapped reads return zero
   always_comb begin
      st_nxt = st_r;
      if (bus.ld_en) begin
         st_nxt.img[bus.ld_slot] = bus.ld_data & vtc_mask(bus.ld_slot);
      end
      if (bus.rd_en) begin
         st_nxt.rd_data = bus.rd_hit ? st_r.img[bus.rd_slot] : 8'h00;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '{img: {`VTC_SLOTS{`VTC_TRIM_RST}}, rd_data: `VTC_TRIM_RST};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign bus.rd_data = st_r.rd_data;
   assign bus.img = st_r.img;

endmodule

/* File: tb/tb.sv */
// Self-checking bench for the trim coefficient bank: APB reads and writes,
// trim loads from the load port, and the assembled coefficient outputs.
// Assumes the bank answers APB in its own time and shows a load one edge later.
`timescale 1ns/1ps

module tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'hF;
   logic pready;
   logic [31:0] prdata;
   logic pslverr;
   logic trim_load_valid = 1'b0;
   logic [7:0] trim_load_addr = 8'h00;
   logic [7:0] trim_load_data = 8'h00;
   logic [13:0] g2;
   logic [11:0] g3;
   logic [11:0] g4;
   logic [13:0] off0;
   logic [4:0] g1_hi;
   logic g1_lsb;
   int err_count = 0;
   int n_compared = 0;
   logic [15:0] lfsr = 16'h002D;
   logic [7:0] mdl [8'h50:8'h5F];

   vtc_trim_bank vtc_trim_bank_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .trim_load_valid(trim_load_valid), .trim_load_addr(trim_load_addr),
      .trim_load_data(trim_load_data), .gain_order2_coeff(g2),
      .gain_order3_coeff(g3), .gain_order4_coeff(g4),
      .offset_order0_coeff(off0), .gain_order1_coeff_hi(g1_hi),
      .gain_order1_coeff_lsb(g1_lsb)
   );

   // 40 ns period
   always #20 pclk = ~pclk;

   // Galois LFSR, seed fixed so every run sees the same stimulus
   function logic [7:0] rnd();
      lfsr = {1'b0, lfsr[15:1]} ^ (lfsr[0] ? 16'hB400 : 16'h0000);
      return lfsr[7:0];
   endfunction

   // Bits that really hold trim data; unmapped offsets hold nothing
   function logic [7:0] msk(input logic [7:0] a);
      if (a == 8'h52) return 8'h80;
      if (a == 8'h57) return 8'h7F;
      if (a == 8'h5B) return 8'h03;
      if (a >= 8'h54 && a <= 8'h5A) return 8'hFF;
      return 8'h00;
   endfunction

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // One APB transfer; request held until pready is sampled high.
   // Leaves psel up so a following setup can start at once.
   task automatic apb(input logic wr, input logic [11:0] a, output logic [31:0] rd,
                      output logic er);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {rnd(), rnd(), rnd(), rnd()};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
   endtask

   task automatic apb_idle();
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Reads every offset around the bank, back to back
   task automatic read_all();
      logic [31:0] rd;
      logic er;
      logic [7:0] a;
      for (int i = 8'h50; i < 8'h60; i++) begin
         a = i[7:0];
         apb(1'b0, {2'b00, a, 2'b00}, rd, er);
         chk("prdata", {24'h0, mdl[a] & msk(a)}, rd);
         chk("pslverr", {31'h0, (a != 8'h52 && msk(a) == 8'h00)}, {31'h0, er});
      end
      apb_idle();
   endtask

   task automatic chk_coef();
      chk("gain2", {18'h0, mdl[8'h56][2:0], mdl[8'h55], mdl[8'h54][7:5]}, {18'h0, g2});
      chk("gain3", {20'h0, mdl[8'h57][6:0], mdl[8'h56][7:3]}, {20'h0, g3});
      chk("gain4", {20'h0, mdl[8'h59][3:0], mdl[8'h58]}, {20'h0, g4});
      chk("offset0", {18'h0, mdl[8'h5B][1:0], mdl[8'h5A], mdl[8'h59][7:4]}, {18'h0, off0});
      chk("gain1 hi", {27'h0, mdl[8'h54][4:0]}, {27'h0, g1_hi});
      chk("gain1 lsb", {31'h0, mdl[8'h52][7]}, {31'h0, g1_lsb});
   endtask

   // Loads every offset back to back, unmapped ones included
   task automatic load_all(input logic all_ones);
      logic [7:0] d;
      for (int i = 8'h50; i < 8'h60; i++) begin
         d = all_ones ? 8'hFF : rnd();
         trim_load_valid <= 1'b1;
         trim_load_addr <= i[7:0];
         trim_load_data <= d;
         mdl[i] = d & msk(i[7:0]);
         @(posedge pclk);
      end
      trim_load_valid <= 1'b0;
      @(posedge pclk);
   endtask

   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      wrap_up();
   end

   initial begin
      logic [31:0] rd;
      logic er;
      for (int i = 8'h50; i < 8'h60; i++) mdl[i] = 8'h00;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      read_all();
      chk_coef();
      $display("test reset values done");
      // All ones first: spare and unused bits must stay clear
      for (int r = 0; r < 4; r++) begin
         load_all(r == 0);
         read_all();
         chk_coef();
      end
      $display("test trim loads done");
      // Writes everywhere, then nothing may have moved
      for (int i = 8'h50; i < 8'h60; i++) begin
         apb(1'b1, {2'b00, i[7:0], 2'b00}, rd, er);
         chk("write err", {31'h0, msk(i[7:0]) == 8'h00}, {31'h0, er});
      end
      apb_idle();
      read_all();
      chk_coef();
      $display("test write ignored done");
      // Misaligned and out-of-range addresses
      apb(1'b0, 12'h155, rd, er);
      chk("misaligned err", 32'h1, {31'h0, er});
      chk("misaligned data", 32'h0, rd);
      apb(1'b0, 12'h554, rd, er);
      chk("high addr err", 32'h1, {31'h0, er});
      apb_idle();
      $display("test bad address done");
      // Reset after loads must clear the whole bank again
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 8'h50; i < 8'h60; i++) mdl[i] = 8'h00;
      @(posedge pclk);
      read_all();
      chk_coef();
      $display("test reset after load done");
      wrap_up();
   end
endmodule
